// ===== logic/aersc_pkg.sv
// package: offsets, field layouts and reset values of the severity and correctable status block
package aersc_pkg;
  localparam int          AERSC_AW            = 12;
  localparam int          AERSC_DW            = 32;
  localparam logic [11:0] AERSC_OFF_SEVERITY  = 12'h10c;
  localparam logic [11:0] AERSC_OFF_CORR_STAT = 12'h110;
  localparam logic [11:0] AERSC_OFF_UNC_MASK  = 12'h108;
  localparam logic [11:0] AERSC_OFF_EVT_STAT  = 12'h130;

  // severity register fields
  localparam logic [31:0] AERSC_SEV_RW_MASK   = 32'h001f3031;
  localparam logic [31:0] AERSC_SEV_RESET     = 32'h00062030;
  localparam logic [31:0] AERSC_SEV_EVT_MASK  = 32'h001f3030;
  localparam int          AERSC_SEV_COMPLETION_TIMEOUT    = 14;
  localparam int          AERSC_SEV_COMPLETER_ABORT    = 15;
  localparam int          AERSC_SEV_LEGACY    = 0;

  // correctable status fields
  localparam logic [31:0] AERSC_CES_MASK      = 32'h000031c1;
  localparam logic [31:0] AERSC_CES_RESET     = 32'h00000000;
  localparam int          AERSC_CES_RECEIVER_ERROR    = 0;
  localparam int          AERSC_CES_BAD_TRANSACTION_PACKET    = 6;
  localparam int          AERSC_CES_BADLNK    = 7;
  localparam int          AERSC_CES_ROLLOVER  = 8;
  localparam int          AERSC_CES_REPLAYTO  = 12;
  localparam int          AERSC_CES_ADVNF     = 13;

  localparam logic [31:0] AERSC_ZERO          = 32'h00000000;
  localparam logic [1:0]  AERSC_EVT_STAT_W    = 2'h2;

  typedef enum logic [1:0] {
    AERSC_RD_NONE = 2'b00,
    AERSC_RD_SEV  = 2'b01,
    AERSC_RD_CES  = 2'b10,
    AERSC_RD_EVT  = 2'b11
  } aersc_rdsel_t;
endpackage

// ===== logic/aersc_ev_if.sv
// interface: uncorrectable events and the fatal or non-fatal classification
`timescale 1ns/10ps
interface aersc_ev_if;
  logic [31:0] events;
  logic [31:0] mask;
  logic [31:0] severity;
  logic [31:0] fatal_hits;
  logic [31:0] nonfatal_hits;
  modport classifier (
    input  events,
    input  mask,
    input  severity,
    output fatal_hits,
    output nonfatal_hits
  );
  modport owner (
    output events,
    output mask,
    output severity,
    input  fatal_hits,
    input  nonfatal_hits
  );
endinterface

// ===== logic/aersc_classify.sv
// module: splits unmasked uncorrectable events by their severity bit
`timescale 1ns/10ps
module aersc_classify
  import aersc_pkg::*;
(
  aersc_ev_if.classifier ev  // events, mask and severity in, split hits out
);
  logic [31:0] live;
  // only events that are defined, unmasked and occurring now count
  assign live             = ev.events & ~ev.mask & AERSC_SEV_EVT_MASK;
  assign ev.fatal_hits    = live & ev.severity;
  assign ev.nonfatal_hits = live & ~ev.severity;
endmodule

// ===== logic/aersc_top.sv
// top: uncorrectable severity and correctable status registers with event reporting
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
// Contract
// - severity applies only to unmasked, occurring events
// - severity one reports event as fatal
// - severity zero reports event as non-fatal
// - bit 4 link protocol, sticky, resets one
// - bit 5 surprise down, sticky, resets one
// - bit 12 poisoned packet, resets zero
// - bit 13 flow credit protocol, resets one
// - bit 16 unexpected completion, resets zero
// - bit 17 receiver overflow, resets one
// - bit 18 bad format packet, resets one
// - bit 19 end-to-end crc, resets zero
// - bit 20 unsupported request, resets zero
// - bit 0 plain storage, no effect
// - bit 14 completion timeout reads zero
// - bit 15 completer abort reads zero
// - status bit 0 receiver error, w1c
// - status bit 6 bad transaction packet
// - status bit 7 bad link packet
// - status bit 8 replay count rollover
// - status bit 12 replay timer expiry
// - status bit 13 advisory non-fatal error
// - masked event neither logged nor reported
module aersc_top
  import aersc_pkg::*;
(
  input  wire logic                clk,                      // 125 MHz clock
  input  wire logic                srst,                     // sync reset, active high
  input  wire logic [AERSC_AW-1:0] reg_addr,                 // register byte address
  input  wire logic [AERSC_DW-1:0] reg_wdata,                // write data
  input  wire logic                reg_wr,                   // write strobe
  input  wire logic                reg_rd,                   // read strobe
  output logic      [AERSC_DW-1:0] reg_rdata,                // read data, cycle after strobe
  input  wire logic [31:0]         unc_events,               // uncorrectable event pulses
  input  wire logic                receiver_error,           // phy receiver error pulse
  input  wire logic                bad_transaction_packet,   // bad packet pulse
  input  wire logic                bad_link_packet,          // bad link packet pulse
  input  wire logic                replay_count_rollover,    // replay rollover pulse
  input  wire logic                replay_timer_expiry,      // replay timer pulse
  input  wire logic                advisory_nonfatal_error,  // advisory non-fatal pulse
  output logic                     fatal_msg,                // fatal report pulse
  output logic                     nonfatal_msg,             // non-fatal report pulse
  output logic                     correctable_msg,          // correctable report pulse
  output logic      [31:0]         unc_log                   // sticky log of reported events
);
  import aersc_pkg::*;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  logic [31:0]  sev_q;
  logic [31:0]  sev_d;
  logic [31:0]  ces_q;
  logic [31:0]  ces_d;
  logic [31:0]  mask_q;
  logic [31:0]  mask_d;
  logic [31:0]  log_q;
  logic [31:0]  corr_set;
  logic [31:0]  sev_view;
  logic [1:0]   evt_q;
  aersc_rdsel_t rdsel;

  aersc_ev_if ev ();
  assign ev.events   = unc_events;
  assign ev.mask     = mask_q;
  assign ev.severity = sev_q;

  aersc_classify u_classify (
    .ev (ev)
  );

  // severity register: only writable fields change, reserved stay zero
  always_comb begin
    sev_d = sev_q;
    if (reg_wr && hit(reg_addr, AERSC_OFF_SEVERITY)) begin
      sev_d = reg_wdata & AERSC_SEV_RW_MASK;
    end
  end

  // sticky fields keep state through srst in a real port; here srst loads defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      sev_q <= AERSC_SEV_RESET;
    end else begin
      sev_q <= sev_d;
    end
  end

  // compl timeout and completer abort never exist in a switch port
  always_comb begin
    sev_view                   = sev_q;
    sev_view[AERSC_SEV_COMPLETION_TIMEOUT] = 1'b0;
    sev_view[AERSC_SEV_COMPLETER_ABORT] = 1'b0;
  end

  // mask register mirrors the port's own mask so events can be gated here
  always_comb begin
    mask_d = mask_q;
    if (reg_wr && hit(reg_addr, AERSC_OFF_UNC_MASK)) begin
      mask_d = reg_wdata & AERSC_SEV_RW_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= AERSC_ZERO;
    end else begin
      mask_q <= mask_d;
    end
  end

  // correctable event set vector
  always_comb begin
    corr_set                     = AERSC_ZERO;
    corr_set[AERSC_CES_RECEIVER_ERROR]   = receiver_error;
    corr_set[AERSC_CES_BAD_TRANSACTION_PACKET]   = bad_transaction_packet;
    corr_set[AERSC_CES_BADLNK]   = bad_link_packet;
    corr_set[AERSC_CES_ROLLOVER] = replay_count_rollover;
    corr_set[AERSC_CES_REPLAYTO] = replay_timer_expiry;
    corr_set[AERSC_CES_ADVNF]    = advisory_nonfatal_error;
  end

  // set wins over a same-cycle write-one-to-clear
  always_comb begin
    ces_d = ces_q;
    if (reg_wr && hit(reg_addr, AERSC_OFF_CORR_STAT)) begin
      ces_d = ces_d & ~reg_wdata;
    end
    ces_d = (ces_d | corr_set) & AERSC_CES_MASK;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ces_q <= AERSC_CES_RESET;
    end else begin
      ces_q <= ces_d;
    end
  end

  // log only unmasked events; masked ones leave no trace
  always_ff @(posedge clk) begin
    if (srst) begin
      log_q <= AERSC_ZERO;
    end else begin
      log_q <= log_q | ev.fatal_hits | ev.nonfatal_hits;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      unc_log <= AERSC_ZERO;
    end else begin
      unc_log <= log_q | ev.fatal_hits | ev.nonfatal_hits;
    end
  end

  // one report pulse per cycle with events; fatal and non-fatal may coincide
  always_ff @(posedge clk) begin
    if (srst) begin
      fatal_msg    <= 1'b0;
      nonfatal_msg <= 1'b0;
    end else begin
      fatal_msg    <= |ev.fatal_hits;
      nonfatal_msg <= |ev.nonfatal_hits;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      correctable_msg <= 1'b0;
    end else begin
      correctable_msg <= |corr_set;
    end
  end

  // last-cycle report flags, readable for software diagnosis
  always_ff @(posedge clk) begin
    if (srst) begin
      evt_q <= 2'b00;
    end else begin
      evt_q <= {|ev.nonfatal_hits, |ev.fatal_hits};
    end
  end

  always_comb begin
    rdsel = AERSC_RD_NONE;
    if (hit(reg_addr, AERSC_OFF_SEVERITY)) begin
      rdsel = AERSC_RD_SEV;
    end else if (hit(reg_addr, AERSC_OFF_CORR_STAT)) begin
      rdsel = AERSC_RD_CES;
    end else if (hit(reg_addr, AERSC_OFF_EVT_STAT)) begin
      rdsel = AERSC_RD_EVT;
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= AERSC_ZERO;
    end else if (reg_rd) begin
      case (rdsel)
        AERSC_RD_SEV: reg_rdata <= sev_view;
        AERSC_RD_CES: reg_rdata <= ces_q;
        AERSC_RD_EVT: reg_rdata <= {30'h0, evt_q};
        AERSC_RD_NONE: begin
          if (hit(reg_addr, AERSC_OFF_UNC_MASK)) begin
            reg_rdata <= mask_q;
          end else begin
            reg_rdata <= AERSC_ZERO;
          end
        end
        default: reg_rdata <= AERSC_ZERO;
      endcase
    end else begin
      reg_rdata <= AERSC_ZERO;
    end
  end

  // checks
  AST_FATAL_ON_SET_SEV: assert property (@(posedge clk) disable iff (srst)
    (|(unc_events & ~mask_q & sev_q & AERSC_SEV_EVT_MASK)) |=> fatal_msg)
    else $error("unmasked fatal-severity event not reported fatal");

  AST_NONFATAL_ON_CLR_SEV: assert property (@(posedge clk) disable iff (srst)
    (|(unc_events & ~mask_q & ~sev_q & AERSC_SEV_EVT_MASK)) |=> nonfatal_msg)
    else $error("unmasked non-fatal event not reported non-fatal");

  AST_MASKED_SILENT: assert property (@(posedge clk) disable iff (srst)
    ((unc_events & ~mask_q & AERSC_SEV_EVT_MASK) == AERSC_ZERO)
      |=> !fatal_msg && !nonfatal_msg)
    else $error("report raised without any unmasked event");

  AST_NO_FATAL_WITHOUT_SEV: assert property (@(posedge clk) disable iff (srst)
    fatal_msg |-> $past(|(unc_events & ~mask_q & sev_q & AERSC_SEV_EVT_MASK)))
    else $error("fatal report with no fatal-severity cause");

  AST_SEV_RESET: assert property (@(posedge clk)
    srst |=> sev_q == AERSC_SEV_RESET)
    else $error("severity reset value wrong");

  AST_SEV_RO_ZERO: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, AERSC_OFF_SEVERITY))
      |=> reg_rdata[AERSC_SEV_COMPLETION_TIMEOUT] == 1'b0 && reg_rdata[AERSC_SEV_COMPLETER_ABORT] == 1'b0)
    else $error("read-only severity bit read as one");

  AST_CES_SET_WINS: assert property (@(posedge clk) disable iff (srst)
    receiver_error |=> ces_q[AERSC_CES_RECEIVER_ERROR])
    else $error("receiver error not captured");

  AST_CES_HOLD: assert property (@(posedge clk) disable iff (srst)
    (ces_q[AERSC_CES_BAD_TRANSACTION_PACKET] && !(reg_wr && hit(reg_addr, AERSC_OFF_CORR_STAT)
      && reg_wdata[AERSC_CES_BAD_TRANSACTION_PACKET])) |=> ces_q[AERSC_CES_BAD_TRANSACTION_PACKET])
    else $error("sticky status bit lost without a clear");

  AST_CES_RESERVED: assert property (@(posedge clk) disable iff (srst)
    (ces_q & ~AERSC_CES_MASK) == AERSC_ZERO && (sev_q & ~AERSC_SEV_RW_MASK) == AERSC_ZERO)
    else $error("reserved bit set");

  AST_CES_W1C: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && hit(reg_addr, AERSC_OFF_CORR_STAT) && reg_wdata[AERSC_CES_ROLLOVER]
      && !replay_count_rollover) |=> !ces_q[AERSC_CES_ROLLOVER])
    else $error("write one did not clear rollover status");

  // severity storage: defaults, writes, stickiness and readback
  AST_SEV_RESET_ZEROS: assert property (@(posedge clk)
    srst |=> (sev_q & ~AERSC_SEV_RESET) == AERSC_ZERO)
    else $error("severity bit set after reset that should be zero");

  AST_SEV_WRITE_LANDS: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && hit(reg_addr, AERSC_OFF_SEVERITY))
      |=> sev_q == ($past(reg_wdata) & AERSC_SEV_RW_MASK))
    else $error("severity write did not land");

  AST_SEV_STICKY: assert property (@(posedge clk) disable iff (srst)
    !(reg_wr && hit(reg_addr, AERSC_OFF_SEVERITY))
      |=> $stable(sev_q))
    else $error("severity changed without a write");

  AST_SEV_READBACK: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, AERSC_OFF_SEVERITY))
      |=> reg_rdata == $past(sev_q))
    else $error("severity read data differs from stored value");

  AST_SEV_RD_RESERVED: assert property (@(posedge clk) disable iff (srst)
    (reg_rd && hit(reg_addr, AERSC_OFF_SEVERITY))
      |=> (reg_rdata & ~AERSC_SEV_RW_MASK) == AERSC_ZERO)
    else $error("reserved or read-only severity bit read as one");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (srst)
    !reg_rd |=> reg_rdata == AERSC_ZERO)
    else $error("read data not zero outside a read");

  // reports: no report without a cause of the matching severity
  AST_NO_NONFATAL_WITHOUT_SEV: assert property (@(posedge clk) disable iff (srst)
    nonfatal_msg |-> $past(|(unc_events & ~mask_q & ~sev_q & AERSC_SEV_EVT_MASK)))
    else $error("non-fatal report with no non-fatal cause");

  AST_FATAL_QUIET: assert property (@(posedge clk) disable iff (srst)
    !(|(unc_events & ~mask_q & sev_q & AERSC_SEV_EVT_MASK))
      |=> !fatal_msg)
    else $error("fatal report with no fatal cause");

  AST_NONFATAL_QUIET: assert property (@(posedge clk) disable iff (srst)
    !(|(unc_events & ~mask_q & ~sev_q & AERSC_SEV_EVT_MASK))
      |=> !nonfatal_msg)
    else $error("non-fatal report with no non-fatal cause");

  // log: unmasked events recorded, masked ones leave it untouched
  AST_LOG_CAPTURE: assert property (@(posedge clk) disable iff (srst)
    (|(unc_events & ~mask_q & AERSC_SEV_EVT_MASK)) |=> ((log_q
      & $past(unc_events & ~mask_q & AERSC_SEV_EVT_MASK))
      == $past(unc_events & ~mask_q & AERSC_SEV_EVT_MASK)))
    else $error("unmasked event not logged");

  AST_LOG_MASKED_STABLE: assert property (@(posedge clk) disable iff (srst)
    !(|(unc_events & ~mask_q & AERSC_SEV_EVT_MASK))
      |=> $stable(log_q))
    else $error("log changed with no unmasked event");

  AST_LOG_NO_UNDEFINED: assert property (@(posedge clk) disable iff (srst)
    (log_q & ~AERSC_SEV_EVT_MASK) == AERSC_ZERO)
    else $error("log holds a position with no event");

  // correctable status: every source sets its own bit
  AST_CES_BAD_TRANSACTION_PACKET_SET: assert property (@(posedge clk) disable iff (srst)
    bad_transaction_packet |=> ces_q[AERSC_CES_BAD_TRANSACTION_PACKET])
    else $error("bad packet status not set");
  AST_CES_BADLNK_SET: assert property (@(posedge clk) disable iff (srst)
    bad_link_packet |=> ces_q[AERSC_CES_BADLNK])
    else $error("bad link packet status not set");
  AST_CES_ROLLOVER_SET: assert property (@(posedge clk) disable iff (srst)
    replay_count_rollover |=> ces_q[AERSC_CES_ROLLOVER])
    else $error("rollover status not set");
  AST_CES_REPLAYTO_SET: assert property (@(posedge clk) disable iff (srst)
    replay_timer_expiry |=> ces_q[AERSC_CES_REPLAYTO])
    else $error("replay timer status not set");
  AST_CES_ADVNF_SET: assert property (@(posedge clk) disable iff (srst)
    advisory_nonfatal_error |=> ces_q[AERSC_CES_ADVNF])
    else $error("advisory status not set");

  AST_CES_RESET_ZERO: assert property (@(posedge clk)
    srst |=> ces_q == AERSC_CES_RESET)
    else $error("status not zero after reset");

  AST_CES_CLEAR_ALL: assert property (@(posedge clk) disable iff (srst)
    (reg_wr && hit(reg_addr, AERSC_OFF_CORR_STAT) && reg_wdata == AERSC_CES_MASK
      && !(|corr_set)) |=> ces_q == AERSC_ZERO)
    else $error("write of ones did not clear status");

  AST_CORR_MSG: assert property (@(posedge clk) disable iff (srst)
    (|corr_set) |=> correctable_msg)
    else $error("correctable event not reported");

  AST_CORR_QUIET: assert property (@(posedge clk) disable iff (srst)
    !(|corr_set)
      |=> !correctable_msg)
    else $error("correctable report with no event");
endmodule

// ===== testbench/aersc_far_end.sv
// far end model: protocol layers raising error event pulses
`timescale 1ns/10ps
module aersc_far_end (
  input  wire logic        clk,         // port clock
  input  wire logic        srst,        // sync reset, active high
  input  wire logic        fire,        // raise the selected events next cycle
  input  wire logic [31:0] unc_sel,     // uncorrectable events to raise
  input  wire logic [5:0]  cor_sel,     // correctable events to raise
  output logic      [31:0] unc_events,  // uncorrectable event pulses
  output logic      [5:0]  cor_events   // {advisory, timer, rollover, link, packet, receiver}
);
  // one-cycle pulses only, as the layers detect each event once
  always_ff @(posedge clk) begin
    if (srst || !fire) begin
      unc_events <= 32'h00000000;
      cor_events <= 6'h00;
    end else begin
      unc_events <= unc_sel;
      cor_events <= cor_sel;
    end
  end
endmodule

// ===== testbench/aer_severity_correctable_log_tb.sv
// testbench: severity and correctable status registers through register and event ports
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module aer_severity_correctable_log_tb;
  import aersc_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        fire = 1'b0;
  logic [31:0] unc_sel = 32'h00000000;
  logic [5:0]  cor_sel = 6'h00;
  logic [31:0] unc_events;
  logic [5:0]  cor_events;
  logic        fatal_msg;
  logic        nonfatal_msg;
  logic        correctable_msg;
  logic [31:0] unc_log;
  logic [31:0] d;
  logic [31:0] sev;
  int          err_total = 0;
  int          check_count = 0;
  int          cycles = 0;
  int          evb[9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};
  int          cpos[6] = '{0, 6, 7, 8, 12, 13};

  always #4 clk = ~clk;

  aersc_far_end aersc_far_end_i (
    .clk        (clk),
    .srst       (srst),
    .fire       (fire),
    .unc_sel    (unc_sel),
    .cor_sel    (cor_sel),
    .unc_events (unc_events),
    .cor_events (cor_events)
  );

  aersc_top aersc_top_i (
    .clk                     (clk),
    .srst                    (srst),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .unc_events              (unc_events),
    .receiver_error          (cor_events[0]),
    .bad_transaction_packet  (cor_events[1]),
    .bad_link_packet         (cor_events[2]),
    .replay_count_rollover   (cor_events[3]),
    .replay_timer_expiry     (cor_events[4]),
    .advisory_nonfatal_error (cor_events[5]),
    .fatal_msg               (fatal_msg),
    .nonfatal_msg            (nonfatal_msg),
    .correctable_msg         (correctable_msg),
    .unc_log                 (unc_log)
  );

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // far end pulses one cycle later, design answers the cycle after
  task automatic raise(input logic [31:0] u, input logic [5:0] c);
    @(posedge clk);
    fire <= 1'b1;
    unc_sel <= u;
    cor_sel <= c;
    @(posedge clk);
    fire <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(AERSC_OFF_SEVERITY, d); `CHK("sev reset", 32'h00062030, d)
    rd(AERSC_OFF_CORR_STAT, d); `CHK("status reset", 32'h00000000, d)
    rd(12'h200, d); `CHK("unmapped read", 32'h00000000, d)
    wr(12'h200, 32'hffffffff);
    rd(AERSC_OFF_SEVERITY, d); `CHK("unmapped write", 32'h00062030, d)
    // masked events leave no log and no report
    wr(AERSC_OFF_UNC_MASK, 32'h001f3031);
    raise(32'h001f3031, 6'h00); `CHK("masked fatal", 1'b0, fatal_msg)
    `CHK("masked nonfatal", 1'b0, nonfatal_msg)
    `CHK("masked log", 32'h00000000, unc_log)
    wr(AERSC_OFF_UNC_MASK, 32'h00000010);
    raise(32'h00000030, 6'h00); `CHK("half masked", 1'b1, fatal_msg)
    `CHK("half log", 32'h00000020, unc_log)
    wr(AERSC_OFF_UNC_MASK, 32'h00000000);
    wr(AERSC_OFF_SEVERITY, 32'hffffffff);
    rd(AERSC_OFF_SEVERITY, d); `CHK("sev ones", 32'h001f3031, d)
    // bit 0 and the hardwired positions never raise a report
    raise(32'h0000c001, 6'h00); `CHK("legacy fatal", 1'b0, fatal_msg)
    `CHK("legacy nonfatal", 1'b0, nonfatal_msg)
    for (int p = 0; p < 2; p++) begin
      sev = (p == 0) ? 32'h00062030 : 32'h00191001;
      wr(AERSC_OFF_SEVERITY, sev);
      rd(AERSC_OFF_SEVERITY, d); `CHK("sev readback", sev, d)
      for (int i = 0; i < 9; i++) begin
        raise(32'h1 << evb[i], 6'h00);
        `CHK("fatal", sev[evb[i]], fatal_msg)
        `CHK("nonfatal", ~sev[evb[i]], nonfatal_msg)
      end
      `CHK("log", 32'h001f3030 | 32'h00000020, unc_log)
    end
    for (int i = 0; i < 6; i++) begin
      raise(32'h00000000, 6'h1 << i); `CHK("corr msg", 1'b1, correctable_msg)
      rd(AERSC_OFF_CORR_STAT, d); `CHK("status set", 32'h1 << cpos[i], d)
      wr(AERSC_OFF_CORR_STAT, ~(32'h1 << cpos[i]));
      rd(AERSC_OFF_CORR_STAT, d); `CHK("status kept", 32'h1 << cpos[i], d)
      wr(AERSC_OFF_CORR_STAT, 32'h1 << cpos[i]);
      rd(AERSC_OFF_CORR_STAT, d); `CHK("status clear", 32'h00000000, d)
    end
    end_of_test();
  end
endmodule
